// File: shared/rxw_cfg.svh
`ifndef RXW_CFG_SVH
`define RXW_CFG_SVH
// Summary of operation
// - Frames enter the buffer only if the receive enable bit in main control is set when their first byte is taken.
// - With reception enabled every frame that passes the filters and does not reach the read pointer is written to the ring buffer.
// - A frame that fails the filters is dropped with no counter, flag or status change.
// - A completed frame bumps the packet count, sets the packet flag and may interrupt.
// - A completed frame advances the hardware write pointer past the stored frame.
// - Each stored frame is preceded by a six-byte header of next pointer and status vector.
// - The write pointer skips one pad byte so that every frame starts on an even address.
// - The clock ready bit clears on power-on reset only and survives every other reset.
// - No write lands on the read pointer; such a frame is aborted and, if it passes the filters, the error flag set.
// - Status bits 15-0 hold the whole frame byte count, stored low byte first.

// Register indices on the register port.
`define RXW_REG_IRQ_ENABLE   4'h0
`define RXW_REG_IRQ_FLAGS    4'h1
`define RXW_REG_STATUS       4'h2
`define RXW_REG_MAIN_CONTROL 4'h3
`define RXW_REG_PKT_COUNT    4'h4
`define RXW_REG_BUF_START    4'h5
`define RXW_REG_BUF_END      4'h6
`define RXW_REG_READ_PTR     4'h7
`define RXW_REG_WRITE_PTR    4'h8
// Bit positions.
`define RXW_BIT_GLOBAL_IE    7
`define RXW_BIT_PKT_IE       6
`define RXW_BIT_RXERR_IE     0
`define RXW_BIT_PKT_FLAG     6
`define RXW_BIT_RXERR_FLAG   0
`define RXW_BIT_INT          7
`define RXW_BIT_RX_BUSY      2
`define RXW_BIT_CLK_READY    0
`define RXW_BIT_RX_ENABLE    2
// Header and reset values.
`define RXW_HDR_LEN          4'h6
`define RXW_HDR_LAST         3'h5
`define RXW_START_RESET      13'h0000
`define RXW_END_RESET        13'h1fff
`define RXW_READ_RESET       13'h0000
`endif

// File: shared/rxw_pkg.sv
package rxw_pkg;
   // One received byte with end-of-frame information from the MAC.
   typedef struct packed {
      logic [15:0] status;
      logic        accept;
      logic        last;
      logic [7:0]  data;
   } rxw_beat_type;

   typedef struct packed {
      logic        we;
      logic [12:0] addr;
      logic [7:0]  data;
   } rxw_mem_wr_type;

   typedef enum logic [1:0] {
      RXW_IDLE = 2'b00,
      RXW_DATA = 2'b01,
      RXW_HDR  = 2'b11
   } rxw_state_type;
endpackage

// File: rtl/rxw_fifo.sv
`timescale 1ns/1ps
module rxw_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 32
) (
   input  wire logic             clock,     // System clock.
   input  wire logic             reset,     // Synchronous reset.
   input  wire logic [WIDTH-1:0] in_data,   // Word to store.
   input  wire logic             in_valid,  // Word offered.
   output logic                  in_ready,  // Room for a word.
   output logic      [WIDTH-1:0] out_data,  // Oldest word.
   output logic                  out_valid, // Oldest word present.
   input  wire logic             out_ready  // Drain side takes the word.
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0]    wr_idx;
   logic [AW-1:0]    rd_idx;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;
   assign out_data = store[rd_idx];

   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   // Ready and valid are flops so the upstream path sees no combinational loop.
   always_ff @(posedge clock) begin
      if (reset) begin
         count     <= '0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
         wr_idx    <= '0;
         rd_idx    <= '0;
      end else begin
         count     <= next_count;
         in_ready  <= next_count != (AW+1)'(DEPTH);
         out_valid <= next_count != '0;
         if (push) begin
            wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
         end
         if (pop) begin
            rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         store[wr_idx] <= in_data;
      end
   end
endmodule

// File: rtl/rxw_writer.sv
`timescale 1ns/1ps
`include "rxw_cfg.svh"
module rxw_writer import rxw_pkg::*; #(
   parameter int AW           = 13,
   parameter int DEPTH        = 32,
   parameter int READY_CYCLES = 16
) (
   input  wire logic           clock,          // 200 MHz system clock.
   input  wire logic           reset,          // Synchronous reset, active high.
   input  wire logic           power_on_reset, // Power-on reset, synchronous, active high.
   input  wire rxw_beat_type   rx_beat,        // Filtered byte stream from the MAC.
   input  wire logic           rx_valid,       // Byte offered.
   output logic                rx_ready,       // Byte taken when high with valid.
   input  wire logic [3:0]     reg_addr,       // Register index.
   input  wire logic           reg_write,      // Write strobe.
   input  wire logic           reg_read,       // Read strobe.
   input  wire logic [15:0]    reg_wdata,      // Write data.
   output logic      [15:0]    reg_rdata,      // Read data, one cycle after the strobe.
   output rxw_mem_wr_type      mem,            // Packet buffer write port.
   output logic                irq_n           // Interrupt, active low.
);
   rxw_beat_type   f_beat;
   logic           f_valid;
   logic           f_ready;
   rxw_state_type  state;
   logic [7:0]     irq_enable;
   logic           pkt_flag;
   logic           rxerr_flag;
   logic [7:0]     main_control;
   logic [7:0]     pkt_count;
   logic           clock_ready;
   logic [7:0]     ready_cnt;
   logic [AW-1:0]  buf_start;
   logic [AW-1:0]  buf_end;
   logic [AW-1:0]  read_ptr;
   logic [AW-1:0]  write_ptr;
   logic [AW-1:0]  data_ptr;
   logic [AW-1:0]  hdr_addr;
   logic [AW-1:0]  next_ptr;
   logic [2:0]     hdr_idx;
   logic [15:0]    byte_count;
   logic [15:0]    frame_status;
   logic           skip;
   logic           ovf;
   logic           take;
   logic [AW-1:0]  cur_addr;
   logic           skip_now;
   logic           ovf_now;
   logic           hdr_hit;
   logic           pkt_evt;
   logic           err_evt;
   logic [AW-1:0]  pad_one;
   logic [7:0]     hdr_byte;
   logic           wr_flags;
   logic           irq_any;

   // Advance an address by n inside the ring, wrapping past the end pointer.
   function automatic logic [AW-1:0] wrap_add(input logic [AW-1:0] a,
                                               input logic [AW-1:0] st,
                                               input logic [AW-1:0] en,
                                               input logic [3:0]    n);
      logic [AW:0] s;
      logic [AW:0] span;
      s    = {1'b0, a} + {{(AW-3){1'b0}}, n};
      span = {1'b0, en} - {1'b0, st} + 1'b1;
      if (s > {1'b0, en}) begin
         s = s - span;
      end
      return s[AW-1:0];
   endfunction

   // The FIFO absorbs MAC bytes while the header is being written.
   rxw_fifo #(
      .WIDTH ($bits(rxw_beat_type)),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clock     (clock),
      .reset     (reset),
      .in_data   (rx_beat),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .out_data  (f_beat),
      .out_valid (f_valid),
      .out_ready (f_ready)
   );

   assign f_ready = state != RXW_HDR;
   assign take    = f_valid && f_ready;

   always_comb begin
      cur_addr = (state == RXW_IDLE) ?
                 wrap_add(write_ptr, buf_start, buf_end, `RXW_HDR_LEN) : data_ptr;
      skip_now = (state == RXW_IDLE) ? !main_control[`RXW_BIT_RX_ENABLE] : skip;
      ovf_now  = ((state == RXW_IDLE) ? 1'b0 : ovf) || (cur_addr == read_ptr);
      hdr_hit  = (state == RXW_HDR) && (hdr_addr == read_ptr);
      pad_one  = wrap_add(data_ptr, buf_start, buf_end, 4'h1);
      next_ptr = pad_one[0] ? wrap_add(data_ptr, buf_start, buf_end, 4'h2) : pad_one;
   end

   assign pkt_evt = (state == RXW_HDR) && !hdr_hit && (hdr_idx == `RXW_HDR_LAST);
   assign err_evt = (take && f_beat.last && f_beat.accept && !skip_now && ovf_now) || hdr_hit;

   always_comb begin
      case (hdr_idx)
         3'h0: hdr_byte = 8'(16'(next_ptr));
         3'h1: hdr_byte = 8'(16'(next_ptr) >> 8);
         3'h2: hdr_byte = byte_count[7:0];
         3'h3: hdr_byte = byte_count[15:8];
         3'h4: hdr_byte = frame_status[7:0];
         default: hdr_byte = frame_status[15:8];
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state        <= RXW_IDLE;
         skip         <= 1'b0;
         ovf          <= 1'b0;
         data_ptr     <= '0;
         byte_count   <= '0;
         frame_status <= '0;
         hdr_idx      <= '0;
         hdr_addr     <= '0;
      end else if (state == RXW_HDR) begin
         hdr_idx  <= hdr_idx + 1'b1;
         hdr_addr <= wrap_add(hdr_addr, buf_start, buf_end, 4'h1);
         if (hdr_hit || pkt_evt) begin
            state <= RXW_IDLE;
         end
      end else if (take) begin
         skip       <= skip_now;
         ovf        <= ovf_now;
         byte_count <= (state == RXW_IDLE) ? 16'h0001 : byte_count + 16'h0001;
         if (!ovf_now) begin
            data_ptr <= (f_beat.last) ? cur_addr : wrap_add(cur_addr, buf_start, buf_end, 4'h1);
         end
         if (!f_beat.last) begin
            state <= RXW_DATA;
         end else if (!skip_now && f_beat.accept && !ovf_now) begin
            state        <= RXW_HDR;
            hdr_idx      <= '0;
            hdr_addr     <= write_ptr;
            frame_status <= f_beat.status;
         end else begin
            state <= RXW_IDLE;
         end
      end
   end

   // Buffer write port; a rejected frame may leave bytes beyond the write pointer only.
   always_ff @(posedge clock) begin
      if (reset) begin
         mem <= '0;
      end else if (state == RXW_HDR) begin
         mem.we   <= !hdr_hit;
         mem.addr <= 13'(hdr_addr);
         mem.data <= hdr_byte;
      end else begin
         mem.we   <= take && !skip_now && !ovf_now;
         mem.addr <= 13'(cur_addr);
         mem.data <= f_beat.data;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         write_ptr <= `RXW_START_RESET;
      end else if (pkt_evt) begin
         write_ptr <= next_ptr;
      end else if (reg_write && reg_addr == `RXW_REG_BUF_START) begin
         write_ptr <= reg_wdata[AW-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         irq_enable   <= '0;
         main_control <= '0;
         buf_start    <= `RXW_START_RESET;
         buf_end      <= `RXW_END_RESET;
         read_ptr     <= `RXW_READ_RESET;
      end else if (reg_write) begin
         case (reg_addr)
            `RXW_REG_IRQ_ENABLE:   irq_enable   <= reg_wdata[7:0];
            `RXW_REG_MAIN_CONTROL: main_control <= reg_wdata[7:0];
            `RXW_REG_BUF_START:    buf_start    <= reg_wdata[AW-1:0];
            `RXW_REG_BUF_END:      buf_end      <= reg_wdata[AW-1:0];
            `RXW_REG_READ_PTR:     read_ptr     <= reg_wdata[AW-1:0];
            default: ;
         endcase
      end
   end

   // Flags are write-one-to-clear; a hardware set in the same cycle wins.
   assign wr_flags = reg_write && reg_addr == `RXW_REG_IRQ_FLAGS;
   always_ff @(posedge clock) begin
      if (reset) begin
         pkt_flag   <= 1'b0;
         rxerr_flag <= 1'b0;
      end else begin
         pkt_flag   <= pkt_evt || (pkt_flag && !(wr_flags && reg_wdata[`RXW_BIT_PKT_FLAG]));
         rxerr_flag <= err_evt || (rxerr_flag && !(wr_flags && reg_wdata[`RXW_BIT_RXERR_FLAG]));
      end
   end

   // A write to the count register is the host's decrement after freeing a frame.
   always_ff @(posedge clock) begin
      if (reset) begin
         pkt_count <= '0;
      end else begin
         case ({pkt_evt, reg_write && reg_addr == `RXW_REG_PKT_COUNT})
            2'b10:   pkt_count <= (pkt_count == 8'hff) ? pkt_count : pkt_count + 8'h01;
            2'b01:   pkt_count <= (pkt_count == 8'h00) ? pkt_count : pkt_count - 8'h01;
            default: pkt_count <= pkt_count;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (power_on_reset) begin
         clock_ready <= 1'b0;
         ready_cnt   <= '0;
      end else if (ready_cnt == 8'(READY_CYCLES)) begin
         clock_ready <= 1'b1;
      end else begin
         ready_cnt <= ready_cnt + 8'h01;
      end
   end

   assign irq_any = irq_enable[`RXW_BIT_GLOBAL_IE] &&
                    ((irq_enable[`RXW_BIT_PKT_IE] && pkt_flag) ||
                     (irq_enable[`RXW_BIT_RXERR_IE] && rxerr_flag));

   always_ff @(posedge clock) begin
      if (reset) begin
         irq_n     <= 1'b1;
         reg_rdata <= '0;
      end else begin
         irq_n <= !irq_any;
         if (reg_read) begin
            case (reg_addr)
               `RXW_REG_IRQ_ENABLE: reg_rdata <= {8'h00, irq_enable};
               `RXW_REG_IRQ_FLAGS: begin
                  reg_rdata <= '0;
                  reg_rdata[`RXW_BIT_PKT_FLAG]   <= pkt_flag;
                  reg_rdata[`RXW_BIT_RXERR_FLAG] <= rxerr_flag;
               end
               `RXW_REG_STATUS: begin
                  reg_rdata <= '0;
                  reg_rdata[`RXW_BIT_INT]       <= irq_any;
                  reg_rdata[`RXW_BIT_RX_BUSY]   <= state != RXW_IDLE;
                  reg_rdata[`RXW_BIT_CLK_READY] <= clock_ready;
               end
               `RXW_REG_MAIN_CONTROL: reg_rdata <= {8'h00, main_control};
               `RXW_REG_PKT_COUNT:    reg_rdata <= {8'h00, pkt_count};
               `RXW_REG_BUF_START:    reg_rdata <= 16'(buf_start);
               `RXW_REG_BUF_END:      reg_rdata <= 16'(buf_end);
               `RXW_REG_READ_PTR:     reg_rdata <= 16'(read_ptr);
               `RXW_REG_WRITE_PTR:    reg_rdata <= 16'(write_ptr);
               default:               reg_rdata <= '0;
            endcase
         end
      end
   end
endmodule

// File: tb/rxw_writer_monitor.sv
`timescale 1ns/1ps
module rxw_writer_monitor import rxw_pkg::*; #(
   parameter int READY_CYCLES = 16
) (
   input wire logic           clock,          // Clock.
   input wire logic           reset,          // Reset.
   input wire logic           power_on_reset, // Power-on reset.
   input wire rxw_beat_type   rx_beat,        // Byte.
   input wire logic           rx_valid,       // Offered.
   input wire logic           rx_ready,       // Taken.
   input wire logic [3:0]     reg_addr,       // Index.
   input wire logic           reg_write,      // Write.
   input wire logic           reg_read,       // Read.
   input wire logic [15:0]    reg_wdata,      // Write data.
   input wire logic [15:0]    reg_rdata,      // Read data.
   input wire rxw_mem_wr_type mem,            // Buffer port.
   input wire logic           irq_n           // Interrupt.
);
   logic [12:0] st, en, rp;
   logic [7:0]  ie, por_cnt, off_cnt;
   logic        rx_on;
   // Shadows of host writes, so the properties can see the pointers.
   always_ff @(posedge clock) begin
      if (reset) begin
         st <= 13'h0000;
         en <= 13'h1fff;
         rp <= 13'h0000;
         ie <= 8'h00;
         rx_on <= 1'b0;
      end else if (reg_write) begin
         case (reg_addr)
            4'h0: ie <= reg_wdata[7:0];
            4'h3: rx_on <= reg_wdata[2];
            4'h5: st <= reg_wdata[12:0];
            4'h6: en <= reg_wdata[12:0];
            4'h7: rp <= reg_wdata[12:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (power_on_reset) por_cnt <= 8'h00;
      else if (por_cnt != 8'hff) por_cnt <= por_cnt + 8'h01;
   end
   // A frame already started may finish after reception is turned off.
   always_ff @(posedge clock) begin
      if (reset || rx_on) off_cnt <= 8'h00;
      else if (off_cnt != 8'hff) off_cnt <= off_cnt + 8'h01;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_stat_rd;
      $past(reg_read) && $past(reg_addr) == 4'h2;
   endsequence
   sequence s_wptr_rd;
      $past(reg_read) && $past(reg_addr) == 4'h8;
   endsequence
   a_clk_rdy_low: assert property (s_stat_rd |->
      por_cnt >= READY_CYCLES || !reg_rdata[0]) else $error("clock ready set too early");
   a_clk_rdy_kept: assert property (s_stat_rd |->
      por_cnt < READY_CYCLES + 4 || reg_rdata[0]) else $error("clock ready not kept");
   a_skip_read_ptr: assert property (mem.we |-> mem.addr != rp)
      else $error("write at read pointer");
   a_stay_in_ring: assert property (mem.we |-> mem.addr >= st && mem.addr <= en)
      else $error("write outside ring");
   a_rx_gated: assert property (mem.we |-> rx_on || off_cnt < 8'h30)
      else $error("write while reception off");
   a_wptr_even: assert property (s_wptr_rd |-> !reg_rdata[0] && reg_rdata[12:0] >= st
      && reg_rdata[12:0] <= en) else $error("write pointer odd or outside ring");
   a_irq_enabled: assert property ($fell(irq_n) |-> ie[7])
      else $error("interrupt without global enable");
   a_irq_held: assert property ($rose(irq_n) |-> $past(reg_write)
      || $past(reg_write, 2) || $past(reg_write, 3))
      else $error("interrupt dropped without host write");
endmodule

// File: tb/rxw_host_model.sv
`timescale 1ns/1ps
module rxw_host_model (
   input  wire logic        clock,     // Clock.
   input  wire logic [15:0] reg_rdata, // Read data.
   output logic      [3:0]  reg_addr,  // Index.
   output logic             reg_write, // Write strobe.
   output logic             reg_read,  // Read strobe.
   output logic      [15:0] reg_wdata  // Write data.
);
   initial begin
      reg_addr = 4'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_wdata = 16'h0000;
   end
   // Strobes last one cycle and move only at the falling edge.
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clock);
      reg_write = 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [15:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge clock);
      reg_read = 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask
   task setup(input logic [12:0] s, e, r);
      wr(4'h5, {3'h0, s});
      wr(4'h6, {3'h0, e});
      wr(4'h7, {3'h0, r});
   endtask
   task start_rx(input logic [7:0] ie);
      wr(4'h1, 16'h0041);
      wr(4'h0, {8'h00, ie});
      wr(4'h3, 16'h0004);
   endtask
endmodule

// File: tb/rxw_writer_tb_top.sv
`timescale 1ns/1ps
module rxw_writer_tb_top import rxw_pkg::*;;
   localparam logic [12:0] ST = 13'h0100;
   localparam logic [12:0] EN = 13'h02ff;
   logic           clock = 1'b0, reset = 1'b1, power_on_reset = 1'b1, rx_valid = 1'b0;
   logic           rx_ready, irq_n, reg_write, reg_read;
   rxw_beat_type   rx_beat = '0;
   rxw_mem_wr_type mem;
   logic [3:0]     reg_addr;
   logic [15:0]    reg_wdata, reg_rdata, v;
   logic [12:0]    wp, rp;
   logic [7:0]     ram [0:8191];
   int             fail_count = 0, n_tests = 0, cyc = 0, stalls = 0;
   always #2.5 clock = ~clock;
   always @(posedge clock) if (mem.we) ram[mem.addr] <= mem.data;
   rxw_writer #(.READY_CYCLES(8)) dut (.clock(clock), .reset(reset),
      .power_on_reset(power_on_reset), .rx_beat(rx_beat), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mem(mem), .irq_n(irq_n));
   rxw_host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata));
   task check(input string nm, input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         close_out;
      end
   end
   function logic [12:0] wrap(input logic [12:0] x);
      return (x > EN) ? x - (EN - ST + 13'h1) : x;
   endfunction
   function logic [7:0] at(input int k);
      return ram[wrap(wp + 13'(k))];
   endfunction
   task put(input logic [7:0] d, input logic l, a, input logic [15:0] s);
      @(negedge clock);
      rx_valid = 1'b1;
      rx_beat = {s, a, l, d};
      // Ready is a flop, so its value at the falling edge is what the next rising edge uses.
      while (rx_ready !== 1'b1) begin
         stalls++;
         @(negedge clock);
      end
      @(posedge clock);
   endtask
   task send(input int n, input logic [7:0] sd, input logic a);
      for (int i = 0; i < n; i++) put(sd + 8'(i), i == n - 1, a, {sd, 8'h80});
      @(negedge clock);
      rx_valid = 1'b0;
   endtask
   task wait_count(input logic [15:0] c);
      for (int i = 0; i < 400; i++) begin
         host.rd(4'h4, v);
         if (v === c) break;
      end
      check("packet count", v, c);
   endtask
   task frame_ok(input int n, input logic [7:0] sd);
      logic [12:0] nx;
      nx = wrap(wp + 13'h6 + 13'(n));
      if (nx[0]) nx = wrap(nx + 13'h1);
      check("next pointer", {at(1), at(0)}, {3'h0, nx});
      check("byte count", {at(3), at(2)}, 16'(n));
      check("status", {at(5), at(4)}, {sd, 8'h80});
      for (int i = 0; i < n; i++) check("data", {8'h00, at(6 + i)}, {8'h00, sd + 8'(i)});
      wp = nx;
   endtask
   task t_reset;
      logic [3:0]  a [6];
      logic [15:0] e [6];
      a = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf};
      e = '{16'h0000, 16'h0000, 16'h1fff, 16'h0000, 16'h0000, 16'h0000};
      host.rd(4'h2, v);
      check("clock ready early", v & 16'h0001, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         host.rd(a[i], v);
         check("reset value", v, e[i]);
      end
      repeat (12) @(negedge clock);
      host.rd(4'h2, v);
      check("clock ready", v & 16'h0001, 16'h0001);
      reset = 1'b1;
      repeat (4) @(negedge clock);
      reset = 1'b0;
      host.rd(4'h2, v);
      check("clock ready kept", v & 16'h0001, 16'h0001);
   endtask
   task t_disabled;
      send(4, 8'h10, 1'b1);
      repeat (30) @(negedge clock);
      host.rd(4'h8, v);
      check("pointer while off", v, {3'h0, wp});
      host.rd(4'h4, v);
      check("count while off", v, 16'h0000);
   endtask
   task t_accept;
      host.start_rx(8'h00);
      send(5, 8'h20, 1'b1);
      wait_count(16'h0001);
      frame_ok(5, 8'h20);
      host.rd(4'h8, v);
      check("write pointer", v, {3'h0, wp});
      host.rd(4'h1, v);
      check("packet flag", v & 16'h0041, 16'h0040);
      check("irq masked", 16'(irq_n), 16'h0001);
      host.wr(4'h0, 16'h00c0);
      repeat (3) @(negedge clock);
      check("irq raised", 16'(irq_n), 16'h0000);
      host.wr(4'h1, 16'h0040);
      repeat (3) @(negedge clock);
      check("irq cleared", 16'(irq_n), 16'h0001);
      send(4, 8'h30, 1'b1);
      wait_count(16'h0002);
      frame_ok(4, 8'h30);
      check("irq again", 16'(irq_n), 16'h0000);
   endtask
   task t_reject;
      host.wr(4'h1, 16'h0041);
      send(6, 8'h40, 1'b0);
      repeat (40) @(negedge clock);
      host.rd(4'h8, v);
      check("pointer kept", v, {3'h0, wp});
      host.rd(4'h4, v);
      check("count kept", v, 16'h0002);
      host.rd(4'h1, v);
      check("flags kept", v & 16'h0041, 16'h0000);
      check("irq kept", 16'(irq_n), 16'h0001);
   endtask
   // Single-byte frames drain slower than they arrive, so the FIFO must refuse.
   task t_burst;
      host.wr(4'h7, {3'h0, wp - 13'h1});
      stalls = 0;
      for (int k = 0; k < 62; k++) send(1, 8'(k), 1'b1);
      wait_count(16'h0040);
      check("fifo refused", 16'(stalls > 0), 16'h0001);
      for (int k = 0; k < 62; k++) frame_ok(1, 8'(k));
   endtask
   task t_overrun;
      host.wr(4'h1, 16'h0041);
      host.wr(4'h0, 16'h0081);
      rp = wrap(wp + 13'h00a);
      host.wr(4'h7, {3'h0, rp});
      ram[rp] = 8'h5a;
      send(16, 8'h50, 1'b1);
      repeat (60) @(negedge clock);
      host.rd(4'h1, v);
      check("error flag", v & 16'h0041, 16'h0001);
      check("read pointer byte", {8'h00, ram[rp]}, 16'h005a);
      host.rd(4'h4, v);
      check("count after abort", v, 16'h0040);
      check("error irq", 16'(irq_n), 16'h0000);
   endtask
   initial begin
      repeat (4) @(negedge clock);
      reset = 1'b0;
      power_on_reset = 1'b0;
      t_reset;
      host.setup(ST, EN, EN);
      wp = ST;
      t_disabled;
      t_accept;
      t_reject;
      t_burst;
      t_overrun;
      close_out;
   end
endmodule
bind rxw_writer rxw_writer_monitor #(.READY_CYCLES(READY_CYCLES)) mon (.clock(clock),
   .reset(reset), .power_on_reset(power_on_reset), .rx_beat(rx_beat), .rx_valid(rx_valid),
   .rx_ready(rx_ready), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mem(mem), .irq_n(irq_n));
